// File: verilog/delay_counter_pkg.sv
// Constants and carrier types shared by the tape delay counter and its bench.
// Assumes a 50 MHz system clock and Avalon-MM byte addressing of 32-bit words.
package delay_counter_pkg;

  // Counter geometry: nine stages, weights 1 through 256.
  localparam int unsigned STAGES = 9;
  localparam int unsigned OSC_COUNT = 6;
  localparam int unsigned ADDR_W = 5;

  // Register byte offsets.
  localparam logic [4:0] CTRL_OFFSET = 5'h00;
  localparam logic [4:0] START_OFFSET = 5'h04;
  localparam logic [4:0] STOP_OFFSET = 5'h08;
  localparam logic [4:0] COUNT_OFFSET = 5'h0C;
  localparam logic [4:0] STATUS_OFFSET = 5'h10;

  // Control register field positions.
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_MSEC_BIT = 1;
  localparam int unsigned CTRL_HI_DENS_BIT = 2;
  localparam int unsigned CTRL_STOP_EN_BIT = 3;
  localparam int unsigned CTRL_BREAK_BIT = 4;

  // Status register field positions (taps are sticky, write one to clear).
  localparam int unsigned STAT_RUNNING_BIT = 0;
  localparam int unsigned STAT_MODEL_TWO_BIT = 1;
  localparam int unsigned STAT_TAP36_BIT = 4;
  localparam int unsigned STAT_TAP52_BIT = 5;
  localparam int unsigned STAT_TAP144_BIT = 6;
  localparam int unsigned STAT_STOPPED_BIT = 7;

  // Decoded tap counts.
  localparam logic [8:0] TAP_36_COUNT = 9'h024;
  localparam logic [8:0] TAP_52_COUNT = 9'h034;
  localparam logic [8:0] TAP_144_COUNT = 9'h090;

  // Reset values.
  localparam logic [8:0] COUNT_RESET = 9'h000;
  localparam logic [8:0] STOP_RESET = 9'h1FF;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  // Oscillator slots: three per drive model.
  typedef enum logic [2:0] {
    OSC_ONE_USEC_LO = 3'b000,
    OSC_ONE_USEC_HI = 3'b001,
    OSC_ONE_MSEC = 3'b010,
    OSC_TWO_USEC_LO = 3'b011,
    OSC_TWO_USEC_HI = 3'b100,
    OSC_TWO_MSEC = 3'b101
  } osc_sel_e;

  // Software control fields.
  typedef struct packed {
    logic break_open;
    logic stop_en;
    logic hi_density;
    logic msec_mode;
    logic run;
  } ctrl_s;

  // Tap pulse group.
  typedef struct packed {
    logic tap_144;
    logic tap_52;
    logic tap_36;
  } taps_s;

endpackage

// File: verilog/tape_delay_counter.sv
// Nine-stage tape delay counter with oscillator routing and a breakable drive line.
// Assumes oscillator pins and the model-two line are asynchronous to MCLK_IN and
// that software reaches the registers over an Avalon-MM slave with waitrequest.
`timescale 1ns/1ns

module tape_delay_counter
  import delay_counter_pkg::*;
#(
  parameter int unsigned WIDTH = 9
)
(
  // Clock and reset.
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  // Avalon-MM slave.
  input wire logic [delay_counter_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  // Tape drive and oscillator pins.
  input wire logic [delay_counter_pkg::OSC_COUNT-1:0] OSC_IN,
  input wire logic DRIVE_MODEL_TWO_SELECTED_READY_IN,
  // Breakable drive line toward the external system.
  output logic DRIVE_PULSE_OUT,
  input wire logic DRIVE_PULSE_RETURN_IN,
  // Counter stages and decoded taps.
  output logic [WIDTH-1:0] DELAY_STAGE_OUT,
  output logic READ_DISC_DELAY_TAP_36_OUT,
  output logic READ_DISC_DELAY_TAP_144_OUT,
  output logic WRITE_DELAY_TAP_52_OUT
);
  import delay_counter_pkg::*;

  // Reset release synchroniser; the second stage is the design-wide reset.
  logic [1:0] rst_sync_q;
  logic rst_n;

  // Bus handshake state.
  logic wait_q;
  logic [31:0] rdata_q;
  logic bus_req;
  logic bus_go;

  // Software-visible state.
  ctrl_s ctrl_q;
  logic [WIDTH-1:0] stop_q;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [3:0] tap_flag_q;
  logic running;

  // Pin synchronisers and edge detection.
  logic [OSC_COUNT-1:0] osc_s1_q;
  logic [OSC_COUNT-1:0] osc_s2_q;
  logic [OSC_COUNT-1:0] osc_prev_q;
  logic [OSC_COUNT-1:0] osc_edge;
  logic [1:0] model_sync_q;
  logic [1:0] ret_sync_q;
  logic ret_prev_q;
  logic ret_edge;

  // Drive routing.
  osc_sel_e osc_sel;
  logic drive_pulse_q;
  logic step;

  // Tap decode.
  taps_s taps;
  taps_s taps_q;
  logic stop_hit;

  // The weight-one and weight-top stages, named for clarity in waveforms.
  logic delay_stage_weight_one;
  logic delay_stage_weight_top;

  assign rst_n = rst_sync_q[1];
  assign running = ctrl_q.run;
  assign delay_stage_weight_one = count_q[0];
  assign delay_stage_weight_top = count_q[WIDTH-1];

  // Reset is applied at once but released only after two clean clock edges.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rst_sync_q <= 2'b00;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Each oscillator pin is synchronised and edge detected in its own slice.
  // The edge detector looks only at the second stage, never the first.
  genvar gi;
  generate
    for (gi = 0; gi < OSC_COUNT; gi = gi + 1)
    begin : g_osc
      always_ff @(posedge MCLK_IN or negedge rst_n)
      begin
        if (!rst_n)
        begin
          osc_s1_q[gi] <= 1'b0;
          osc_s2_q[gi] <= 1'b0;
          osc_prev_q[gi] <= 1'b0;
        end
        else
        begin
          osc_s1_q[gi] <= OSC_IN[gi];
          osc_s2_q[gi] <= osc_s1_q[gi];
          osc_prev_q[gi] <= osc_s2_q[gi];
        end
      end
      // A rising oscillator edge becomes one drive pulse of one clock.
      assign osc_edge[gi] = osc_s2_q[gi] & ~osc_prev_q[gi];
    end
  endgenerate

  // Model-two ready line and the external return line are pins too.
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      model_sync_q <= 2'b00;
      ret_sync_q <= 2'b00;
      ret_prev_q <= 1'b0;
    end
    else
    begin
      model_sync_q <= {model_sync_q[0], DRIVE_MODEL_TWO_SELECTED_READY_IN};
      ret_sync_q <= {ret_sync_q[0], DRIVE_PULSE_RETURN_IN};
      ret_prev_q <= ret_sync_q[1];
    end
  end

  // The returned line counts on its rising edge, like an oscillator.
  assign ret_edge = ret_sync_q[1] & ~ret_prev_q;

  // Oscillator choice: drive model picks the set, mode and density the member.
  always_comb
  begin
    if (model_sync_q[1])
    begin
      if (ctrl_q.msec_mode)
      begin
        osc_sel = OSC_TWO_MSEC;
      end
      else if (ctrl_q.hi_density)
      begin
        osc_sel = OSC_TWO_USEC_HI;
      end
      else
      begin
        osc_sel = OSC_TWO_USEC_LO;
      end
    end
    else if (ctrl_q.msec_mode)
    begin
      osc_sel = OSC_ONE_MSEC;
    end
    else if (ctrl_q.hi_density)
    begin
      osc_sel = OSC_ONE_USEC_HI;
    end
    else
    begin
      osc_sel = OSC_ONE_USEC_LO;
    end
  end

  // Only a running counter receives drive pulses from the chosen oscillator.
  // The pulse is registered so that the break-out pin comes from a flop.
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_pulse_q <= 1'b0;
    end
    else
    begin
      drive_pulse_q <= running & osc_edge[osc_sel];
    end
  end

  // With the break point closed the internal pulse steps the counter directly.
  // When opened, the external system owns the step and must send it back.
  // The returned pulse is still gated by run, so software stop always wins.
  assign step = ctrl_q.break_open ? (ret_edge & running) : drive_pulse_q;

  // Next count: add one per drive pulse, hold otherwise.
  always_comb
  begin
    if (step)
    begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
    else
    begin
      count_d = count_q;
    end
  end

  // Hitting the programmed stop count halts the counter on that exact step.
  assign stop_hit = step & ctrl_q.stop_en & (count_d == stop_q);

  // Taps decode a count only on the step that reaches it, so a held count
  // does not re-fire its tap.
  assign taps.tap_36 = step & (count_d == TAP_36_COUNT[WIDTH-1:0]);
  assign taps.tap_52 = step & (count_d == TAP_52_COUNT[WIDTH-1:0]);
  assign taps.tap_144 = step & (count_d == TAP_144_COUNT[WIDTH-1:0]);

  // Bus request is taken once per waitrequest-low cycle.
  assign bus_req = AVS_READ_IN | AVS_WRITE_IN;
  assign bus_go = bus_req & ~wait_q;

  // Waitrequest drops for one cycle after a request is seen, then rises again.
  // This fixed two-edge answer keeps the slave simple at the cost of throughput.
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 1'b1;
    end
    else if (bus_req && wait_q)
    begin
      wait_q <= 1'b0;
    end
    else
    begin
      wait_q <= 1'b1;
    end
  end

  // Read data is captured together with the waitrequest drop.
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= READ_UNMAPPED;
    end
    else if (AVS_READ_IN && wait_q)
    begin
      if (AVS_ADDRESS_IN == CTRL_OFFSET)
      begin
        rdata_q <= {27'h0000000, ctrl_q};
      end
      else if (AVS_ADDRESS_IN == START_OFFSET)
      begin
        // The start register has no storage of its own; it reads the count.
        rdata_q <= {{(32-WIDTH){1'b0}}, count_q};
      end
      else if (AVS_ADDRESS_IN == STOP_OFFSET)
      begin
        rdata_q <= {{(32-WIDTH){1'b0}}, stop_q};
      end
      else if (AVS_ADDRESS_IN == COUNT_OFFSET)
      begin
        rdata_q <= {{(32-WIDTH){1'b0}}, count_q};
      end
      else if (AVS_ADDRESS_IN == STATUS_OFFSET)
      begin
        rdata_q <= {24'h000000, tap_flag_q[3], tap_flag_q[2:0], 2'b00,
                    model_sync_q[1], running};
      end
      else
      begin
        // Unmapped addresses answer normally with zero data.
        rdata_q <= READ_UNMAPPED;
      end
    end
  end

  // Control register; a hardware stop clears run unless software writes it.
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= '0;
    end
    else if (bus_go && AVS_WRITE_IN && AVS_ADDRESS_IN == CTRL_OFFSET)
    begin
      ctrl_q <= AVS_WRITEDATA_IN[4:0];
    end
    else if (stop_hit)
    begin
      ctrl_q.run <= 1'b0;
    end
  end

  // Stop count register.
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stop_q <= STOP_RESET[WIDTH-1:0];
    end
    else if (bus_go && AVS_WRITE_IN && AVS_ADDRESS_IN == STOP_OFFSET)
    begin
      stop_q <= AVS_WRITEDATA_IN[WIDTH-1:0];
    end
  end

  // The counter: a start write presets any count, steps advance it.
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= COUNT_RESET[WIDTH-1:0];
    end
    else if (bus_go && AVS_WRITE_IN && AVS_ADDRESS_IN == START_OFFSET)
    begin
      count_q <= AVS_WRITEDATA_IN[WIDTH-1:0];
    end
    else
    begin
      count_q <= count_d;
    end
  end

  // Sticky tap and stop flags; a new event beats a same-cycle clear.
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tap_flag_q <= 4'h0;
    end
    else if (bus_go && AVS_WRITE_IN && AVS_ADDRESS_IN == STATUS_OFFSET)
    begin
      tap_flag_q <= (tap_flag_q & ~AVS_WRITEDATA_IN[7:4]) | {stop_hit, taps};
    end
    else
    begin
      tap_flag_q <= tap_flag_q | {stop_hit, taps};
    end
  end

  // Tap outputs are one-clock pulses delayed one edge behind the step.
  always_ff @(posedge MCLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      taps_q <= '0;
    end
    else
    begin
      taps_q <= taps;
    end
  end

  // Every top-level output comes straight from a flop.
  assign AVS_WAITREQUEST_OUT = wait_q;
  assign AVS_READDATA_OUT = rdata_q;
  assign DRIVE_PULSE_OUT = drive_pulse_q;
  assign DELAY_STAGE_OUT = count_q;
  assign READ_DISC_DELAY_TAP_36_OUT = taps_q.tap_36;
  assign READ_DISC_DELAY_TAP_144_OUT = taps_q.tap_144;
  assign WRITE_DELAY_TAP_52_OUT = taps_q.tap_52;

endmodule

// File: dv/tdc_properties.sv
// Port checker for the tape delay counter, bound at the foot of this file.
// Assumes one clock domain with an active-low reset input.
`timescale 1ns/1ns
module tdc_props
  import delay_counter_pkg::*;
#(parameter int unsigned WIDTH = 9)
(
  // Clock, reset and bus.
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  // Drive side and taps.
  input wire logic [delay_counter_pkg::OSC_COUNT-1:0] OSC_IN,
  input wire logic DRIVE_MODEL_TWO_SELECTED_READY_IN,
  input wire logic DRIVE_PULSE_OUT,
  input wire logic [WIDTH-1:0] DELAY_STAGE_OUT,
  input wire logic READ_DISC_DELAY_TAP_36_OUT,
  input wire logic WRITE_DELAY_TAP_52_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // A request, and a write completing; only the latter may jump the count.
  logic req;
  logic wr_done;
  assign req = AVS_READ_IN || AVS_WRITE_IN;
  assign wr_done = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  bus_answer_a: assert property (req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("bus answer late");
  wait_single_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("waitrequest low too long");
  rdata_hold_a: assert property (!$stable(AVS_READDATA_OUT) |->
    !AVS_WAITREQUEST_OUT && $past(AVS_READ_IN)) else $error("read data moved");
  count_step_a: assert property (!$stable(DELAY_STAGE_OUT) && !$past(wr_done) |->
    DELAY_STAGE_OUT == WIDTH'($past(DELAY_STAGE_OUT) + 1'b1)) else $error("bad count step");
  // The tap flop and the count flop load from the same step, so a tap stands
  // in the very cycle in which the count first shows its decoded value.
  tap_land_a: assert property (!$stable(DELAY_STAGE_OUT) && !$past(wr_done) &&
    DELAY_STAGE_OUT == TAP_36_COUNT |-> READ_DISC_DELAY_TAP_36_OUT) else $error("tap missed");
  tap_cause_a: assert property (WRITE_DELAY_TAP_52_OUT |->
    DELAY_STAGE_OUT == TAP_52_COUNT && $past(DELAY_STAGE_OUT) != TAP_52_COUNT)
    else $error("stray tap");
  pulse_single_a: assert property (DRIVE_PULSE_OUT |=> !DRIVE_PULSE_OUT [*2])
    else $error("drive pulse too long");
  quiet_hold_a: assert property (($stable(OSC_IN) && !AVS_WRITE_IN &&
    $stable(DRIVE_MODEL_TWO_SELECTED_READY_IN)) [*6] |-> !DRIVE_PULSE_OUT)
    else $error("pulse without oscillator");
  cover property (READ_DISC_DELAY_TAP_36_OUT);
  cover property (DRIVE_PULSE_OUT);
  cover property (wr_done);
endmodule

bind tape_delay_counter tdc_props #(.WIDTH(WIDTH)) props (.MCLK_IN, .RST_N_IN, .AVS_READ_IN,
  .AVS_WRITE_IN, .AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .OSC_IN,
  .DRIVE_MODEL_TWO_SELECTED_READY_IN, .DRIVE_PULSE_OUT, .DELAY_STAGE_OUT,
  .READ_DISC_DELAY_TAP_36_OUT, .WRITE_DELAY_TAP_52_OUT);

// File: dv/drive_osc_model.sv
// Oscillator bank, drive model line and the external logic on the broken line.
// Assumes the bench clock; oscillator pins idle low between periods.
`timescale 1ns/1ns
module drive_osc_model (
  // Bench clock and the drive line leaving the counter.
  input wire logic clk_in,
  input wire logic drive_pulse_in,
  // Lines into the counter.
  output logic [5:0] osc_out,
  output logic model_two_out,
  output logic return_out
);
  logic slow_q = 1'b0; // The external logic answers a cycle late.
  logic block_q = 1'b0; // The external logic withholds its result.
  logic dly_q = 1'b0; // Drive pulse delayed for the late answer.
  initial
  begin
    osc_out = '0;
    model_two_out = 1'b0;
    return_out = 1'b0;
  end
  // One period, three clocks high and three low, keeps edges well apart.
  task automatic pulse(input int i);
    @(posedge clk_in);
    osc_out[i] <= 1'b1;
    repeat (3) @(posedge clk_in);
    osc_out[i] <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  // The external logic hands each drive pulse back to finish its job while block_q is clear.
  always @(posedge clk_in)
  begin
    dly_q <= drive_pulse_in;
    return_out <= (slow_q ? dly_q : drive_pulse_in) && !block_q;
  end
endmodule

// File: dv/tape_delay_counter_tb.sv
// Bench for the tape delay counter: bus tasks, a score model and tap matching.
// Assumes the drive model and the bound checker are compiled first.
`timescale 1ns/1ns
module tape_delay_counter_tb;
  import delay_counter_pkg::*;
  // Bench inputs, defined at time zero.
  logic clk = 0, rst_n = 0, rd = 0, wr = 0;
  logic [4:0] adr = '0;
  logic [31:0] wd = '0, rdat, bq;
  // Design outputs and partner lines.
  logic wq, dp, ret, m2l;
  logic [5:0] osc_v;
  logic [8:0] stage;
  wire taps_s tv;
  // Score model: count, control, stop, sticky flags, model line, expected taps.
  int num_errors = 0, n_checks = 0, cnt = 0, ctl = 0, stp = 511, stk = 0, m2 = 0, r;
  int exp_q[$];
  int starts[4] = '{35, 51, 143, 36};
  tape_delay_counter dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wq), .OSC_IN(osc_v), .DRIVE_MODEL_TWO_SELECTED_READY_IN(m2l),
    .DRIVE_PULSE_OUT(dp), .DRIVE_PULSE_RETURN_IN(ret), .DELAY_STAGE_OUT(stage),
    .READ_DISC_DELAY_TAP_36_OUT(tv.tap_36), .READ_DISC_DELAY_TAP_144_OUT(tv.tap_144),
    .WRITE_DELAY_TAP_52_OUT(tv.tap_52));
  drive_osc_model osc (.clk_in(clk), .drive_pulse_in(dp), .osc_out(osc_v),
    .model_two_out(m2l), .return_out(ret));
  initial forever #10 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One transfer; the request stands until waitrequest is seen low.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (wq !== 1'b0 && i < 20);
    bq = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wq !== 1'b0)
    begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  // Write a register and keep the model in step.
  task automatic wrr(input logic [4:0] a, input int d);
    bus(1'b1, a, d);
    case (a)
      CTRL_OFFSET: ctl = d & 31;
      START_OFFSET: cnt = d & 511;
      STOP_OFFSET: stp = d & 511;
      STATUS_OFFSET: stk &= ~d;
      default: ;
    endcase
  endtask
  task automatic rdck(input logic [4:0] a);
    int e;
    case (a)
      CTRL_OFFSET: e = ctl;
      START_OFFSET, COUNT_OFFSET: e = cnt;
      STOP_OFFSET: e = stp;
      STATUS_OFFSET: e = (ctl & 1) | (m2 << 1) | stk;
      default: e = 0;
    endcase
    bus(1'b0, a, '0);
    check(bq, e);
  endtask
  // Pulse oscillator i n times; only the routed one steps a running count.
  task automatic pul(input int i, input int n);
    int t;
    repeat (n)
    begin
      t = cnt + 1;
      if ((ctl & 1) && i == m2 * 3 + ((ctl & 2) ? 2 : (ctl >> 2) & 1) &&
          !((ctl & 16) && osc.block_q))
      begin
        cnt = t % 512;
        t = (cnt == 36) ? 1 : (cnt == 52) ? 2 : (cnt == 144) ? 4 : 0;
        if (t != 0)
          exp_q.push_back(t);
        stk |= t << 4;
        if ((ctl & 8) && cnt == stp)
        begin
          ctl &= ~1;
          stk |= 128;
        end
      end
      osc.pulse(i);
      repeat (8) @(posedge clk);
    end
    check(stage, cnt);
  endtask
  // Every tap pulse must match the next one the model predicted.
  always @(posedge clk)
    if (rst_n && tv !== 3'b000)
      check(tv, exp_q.size() > 0 ? exp_q.pop_front() : 0);
  initial
  begin
    r = $urandom(19);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values and an unmapped place; the count is read-only.
    for (int k = 0; k < 24; k += 4)
      rdck(5'(k));
    wrr(COUNT_OFFSET, 7);
    pul(0, 1);
    // Every oscillator slot, with the other model's slot left unrouted.
    for (int k = 0; k < 6; k++)
    begin
      m2 = k / 3;
      osc.model_two_out <= 1'(m2);
      wrr(CTRL_OFFSET, 1 | ((k % 3 == 2) ? 2 : 0) | ((k % 3 == 1) ? 4 : 0));
      wrr(START_OFFSET, $urandom % 512);
      pul(k, 2);
      pul((k + 3) % 6, 1);
      rdck(STATUS_OFFSET);
    end
    // Landing on each tap; a preset onto a tap does not fire it.
    foreach (starts[j])
    begin
      wrr(START_OFFSET, starts[j]);
      pul(5, 1);
    end
    rdck(STATUS_OFFSET);
    wrr(STATUS_OFFSET, 32'hF0);
    rdck(STATUS_OFFSET);
    // Stop at a chosen count, then wrap at the top.
    wrr(STOP_OFFSET, 40);
    wrr(START_OFFSET, 38);
    wrr(CTRL_OFFSET, 9);
    pul(3, 3);
    rdck(CTRL_OFFSET);
    wrr(CTRL_OFFSET, 1);
    wrr(START_OFFSET, 511);
    pul(3, 1);
    // Broken drive line: prompt, late and withheld answers.
    wrr(CTRL_OFFSET, 17);
    pul(3, 1);
    osc.slow_q = 1'b1;
    pul(3, 1);
    osc.block_q = 1'b1;
    pul(3, 1);
    osc.block_q = 1'b0;
    wrr(CTRL_OFFSET, 1 | ($urandom % 4) * 2);
    repeat (6)
    begin
      wrr(START_OFFSET, $urandom % 512);
      pul($urandom % 6, 1 + $urandom % 3);
    end
    check(exp_q.size(), 0);
    tally_and_finish();
  end
endmodule
